// >>> rtl/hsdac_slave.sv
// High-speed two-wire write slave of a quad 16-bit converter, with AXI4-Lite registers.
// Assumes scl_in and sda_in come from pins in another domain and are slow versus aclk.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module hsdac_slave
  import hsdac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Converter side
  output logic [CHANNELS*REG_W-1:0] dac_word,
  output logic hs_mode
);
  hsdac_regs_s st;
  hsdac_regs_s next_st;
  // Synchronised link levels and conditions
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic decide;
  logic ack_end;
  logic [1:0] sel;
  logic [1:0] load;
  logic [REG_W-1:0] sel_tr;
  logic [REG_W-1:0] sel_dr;
  assign scl = st.scl_sync[1];
  assign sda = st.sda_sync[1];
  assign scl_rise = scl && !st.scl_prev;
  assign scl_fall = !scl && st.scl_prev;
  assign start_c = scl && st.scl_prev && st.sda_prev && !sda;
  assign stop_c = scl && st.scl_prev && !st.sda_prev && sda;
  assign decide = scl_fall && (st.bitcnt == BYTE_BITS) && !st.ack_phase;
  assign ack_end = scl_fall && st.ack_phase;
  assign sel = st.ctrl[CTRL_SEL_HI:CTRL_SEL_LO];
  assign load = st.ctrl[CTRL_LOAD_HI:CTRL_LOAD_LO];
  assign sel_tr = st.tr[sel];
  assign sel_dr = st.dr[sel];
  // Register read decode; ignores the two low address bits
  function automatic logic [33:0] read_word(input logic [11:0] a, input hsdac_regs_s s);
    logic [11:0] w;
    w = {a[11:2], 2'h0};
    if (w == OFF_CONFIG) begin
      read_word = {RESP_OKAY, 30'h00000000, s.addr_pins};
    end else if (w == OFF_STATUS) begin
      read_word = {RESP_OKAY, 16'h0000, s.ctrl, 4'h0, s.state, s.hs_mode};
    end else if (w[11:4] == OFF_OUT_BASE[11:4]) begin
      read_word = {RESP_OKAY, 14'h0000, s.dr[w[3:2]]};
    end else if (w[11:4] == OFF_TEMP_BASE[11:4]) begin
      read_word = {RESP_OKAY, 14'h0000, s.tr[w[3:2]]};
    end else begin
      read_word = {RESP_SLVERR, 32'h00000000};
    end
  endfunction
  // Next-state logic for link, channel registers and bus slave
  always_comb begin
    logic ack;
    ack = 1'b0;
    next_st = st;
    // Two flops before any logic reads the pins
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};
    next_st.scl_prev = scl;
    next_st.sda_prev = sda;
    if (stop_c) begin
      next_st.state = S_IDLE;
      next_st.hs_mode = 1'b0;
      next_st.bitcnt = 4'h0;
      next_st.ack_phase = 1'b0;
      next_st.sda_oe_n = 1'b1;
      next_st.upd_pend = 1'b0;
    end else if (start_c) begin
      // Repeated start also lands here and ends any data stream
      next_st.state = S_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.ack_phase = 1'b0;
      next_st.sda_oe_n = 1'b1;
      next_st.upd_pend = 1'b0;
    end else begin
      // Sample data on the rising clock edge, MSB first
      if (scl_rise && (st.bitcnt < BYTE_BITS)) begin
        next_st.shreg = {st.shreg[6:0], sda};
        next_st.bitcnt = st.bitcnt + 4'h1;
      end
      // Byte complete: decide acknowledge on the falling edge after bit 0
      if (decide) begin
        case (st.state)
          S_ADDR: begin
            if (st.shreg[7:3] == MASTER_CODE_TOP) begin
              next_st.hs_mode = 1'b1;
              next_st.state = S_IGNORE;
            end else if (st.shreg == {ADDR_FIXED, st.addr_pins, 1'b0}) begin
              ack = 1'b1;
              next_st.state = S_CTRL;
            end else begin
              next_st.state = S_IGNORE;
            end
          end
          S_CTRL: begin
            ack = 1'b1;
            next_st.ctrl = st.shreg;
            // Bad fixed bits: byte is acknowledged but the rest is dropped
            if (st.shreg[CTRL_ZERO_HI] || st.shreg[CTRL_ZERO_MID] || st.shreg[CTRL_ZERO_LO]) begin
              next_st.state = S_IGNORE;
            end else if (st.shreg[CTRL_KIND]) begin
              next_st.state = S_PD_HI;
            end else begin
              next_st.state = S_DATA_HI;
            end
          end
          S_DATA_HI, S_PD_HI: begin
            ack = 1'b1;
            next_st.hi = st.shreg;
            next_st.state = (st.state == S_DATA_HI) ? S_DATA_LO : S_PD_LO;
          end
          S_DATA_LO: begin
            ack = 1'b1;
            next_st.tr[sel] = {2'h0, st.hi, st.shreg};
            next_st.upd_pend = 1'b1;
            next_st.state = S_DATA_HI;
          end
          S_PD_LO: begin
            ack = 1'b1;
            next_st.tr[sel][REG_W-1:DATA_W] = st.hi[PD_MODE_HI:PD_MODE_LO];
            next_st.upd_pend = 1'b1;
            next_st.state = S_IGNORE;
          end
          default: ack = 1'b0;
        endcase
        next_st.ack_phase = 1'b1;
        next_st.sda_oe_n = !ack;
      end
      // End of acknowledge clock: release the line and apply loads
      if (ack_end) begin
        next_st.sda_oe_n = 1'b1;
        next_st.ack_phase = 1'b0;
        next_st.bitcnt = 4'h0;
        next_st.upd_pend = 1'b0;
        if (st.upd_pend) begin
          if (load == LOAD_ALL) begin
            next_st.dr = st.tr;
          end else if (load != LOAD_TEMP) begin
            next_st.dr[sel] = st.tr[sel];
          end
        end
      end
    end
    // AXI write: address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'(read_word(st.awaddr, st) >> 32);
      if ({st.awaddr[11:2], 2'h0} == OFF_CONFIG && st.wstrb[0]) begin
        next_st.addr_pins = st.wdata[1:0];
      end
    end
    // Each ready only while its own channel holds nothing and no response is pending, so a pending response blocks new writes
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    // AXI read: one outstanding read
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      {next_st.rresp, next_st.rdata} = read_word(s_axi_araddr, st);
    end
    next_st.arready = !next_st.rvalid;
  end
  // State register, synchronous reset; samplers start idle-high, so no false link edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.scl_sync <= 2'h3;
      st.sda_sync <= 2'h3;
      st.scl_prev <= 1'b1;
      st.sda_prev <= 1'b1;
      st.sda_oe_n <= 1'b1;
      st.addr_pins <= ADDR_PINS_RESET;
    end else begin
      st <= next_st;
    end
  end
  // Outputs straight from the state register
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign sda_out = st.sda_o;
  assign sda_oe_n = st.sda_oe_n;
  assign dac_word = st.dr;
  assign hs_mode = st.hs_mode;
  // Checks, all on aclk and quiet while reset is low
  default clocking cb_chk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_master_code_nack;
    (decide && st.state == S_ADDR && st.shreg[7:3] == MASTER_CODE_TOP)
      |=> (sda_oe_n && hs_mode) [*2];
  endproperty
  a_master_code_nack: assert property (p_master_code_nack) else $error("code acked");
  property p_addr_ack;
    (decide && st.state == S_ADDR && st.shreg == {ADDR_FIXED, st.addr_pins, 1'b0})
      |=> !sda_oe_n && st.state == S_CTRL;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_read_nack;
    (decide && st.state == S_ADDR && st.shreg[0]) |=> sda_oe_n;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("read address acked");
  property p_ctrl_ack;
    (decide && st.state == S_CTRL) |=> !sda_oe_n && st.ctrl == $past(st.shreg);
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack) else $error("control byte lost");
  property p_kind_route;
    (decide && st.state == S_CTRL && st.shreg[7:6] == 2'h0 && !st.shreg[3])
      |=> st.state == ($past(st.shreg[0]) ? S_PD_HI : S_DATA_HI);
  endproperty
  a_kind_route: assert property (p_kind_route) else $error("wrong data route");
  property p_word_store;
    (decide && st.state == S_DATA_LO)
      |=> sel_tr == {2'h0, $past(st.hi), $past(st.shreg)} && st.state == S_DATA_HI;
  endproperty
  a_word_store: assert property (p_word_store) else $error("word stored wrong");
  property p_pd_store;
    (decide && st.state == S_PD_LO)
      |=> sel_tr[REG_W-1:DATA_W] == $past(st.hi[PD_MODE_HI:PD_MODE_LO]) && !sda_oe_n;
  endproperty
  a_pd_store: assert property (p_pd_store) else $error("pd bits wrong");
  property p_update_moment;
    !(ack_end && st.upd_pend) |=> $stable(st.dr);
  endproperty
  a_update_moment: assert property (p_update_moment) else $error("update off edge");
  property p_update_one;
    (ack_end && st.upd_pend && load == LOAD_ONE) |=> sel_dr == sel_tr;
  endproperty
  a_update_one: assert property (p_update_one) else $error("channel not updated");
  property p_stop_leaves_hs;
    stop_c |=> !hs_mode && st.state == S_IDLE && sda_oe_n;
  endproperty
  a_stop_leaves_hs: assert property (p_stop_leaves_hs) else $error("stop kept hs mode");
endmodule // hsdac_slave

// >>> rtl/hsdac_pkg.sv
// Constants, state encoding and the state record of the high-speed write slave.
// Assumes a single clock domain on the bus side; the link pins are sampled by it.
package hsdac_pkg;

  // Channel geometry
  localparam int CHANNELS = 4;
  localparam int DATA_W = 16;
  localparam int REG_W = 18;

  // Two-wire bus byte patterns
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Control byte field positions
  localparam int CTRL_ZERO_HI = 7;
  localparam int CTRL_ZERO_MID = 6;
  localparam int CTRL_LOAD_HI = 5;
  localparam int CTRL_LOAD_LO = 4;
  localparam int CTRL_ZERO_LO = 3;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_KIND = 0;

  // Power-down bits in the first power-down byte
  localparam int PD_MODE_HI = 7;
  localparam int PD_MODE_LO = 6;

  // Load modes
  localparam logic [1:0] LOAD_TEMP = 2'h0;
  localparam logic [1:0] LOAD_ONE = 2'h1;
  localparam logic [1:0] LOAD_ALL = 2'h2;

  // Register map, byte addresses
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_OUT_BASE = 12'h010;
  localparam logic [11:0] OFF_TEMP_BASE = 12'h020;

  // Reset values
  localparam logic [1:0] ADDR_PINS_RESET = 2'h0;
  localparam logic [REG_W-1:0] CHAN_RESET = 18'h00000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_CTRL, S_DATA_HI, S_DATA_LO, S_PD_HI, S_PD_LO, S_IGNORE
  } hsdac_state_e;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    hsdac_state_e state;
    logic [3:0] bitcnt;
    logic ack_phase;
    logic [7:0] shreg;
    logic [7:0] hi;
    logic [7:0] ctrl;
    logic upd_pend;
    logic hs_mode;
    logic sda_oe_n;
    logic sda_o;
    logic [CHANNELS-1:0][REG_W-1:0] tr;
    logic [CHANNELS-1:0][REG_W-1:0] dr;
    logic [1:0] addr_pins;
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } hsdac_regs_s;

endpackage

// >>> bench/hsdac_master.sv
// Behavioural two-wire bus master that drives the high-speed write slave.
// Assumes the bench resolves SDA with a pull-up and feeds the wire level back.
`timescale 1ns/1ps
module hsdac_master (
  // Sampling clock
  input wire logic aclk,
  // Resolved data wire
  input wire logic sda_line,
  // Master lines, high when released
  output logic scl,
  output logic sda
);
  // Lines idle high from time zero
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda <= 1'b1;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda <= 1'b0;
    hold(4);
    scl <= 1'b0;
    hold(2);
  endtask

  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda <= 1'b0;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda <= 1'b1;
    hold(4);
  endtask

  // One 8-cycle clock; sampled late so the slave's sync delay is covered
  task automatic clk_bit(input logic b, output logic s);
    sda <= b;
    hold(2);
    scl <= 1'b1;
    hold(4);
    s = sda_line;
    scl <= 1'b0;
    hold(2);
  endtask

  // Byte MSB first, then a ninth clock with SDA released
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule // hsdac_master

// >>> bench/hs_mode_dac_write_slave_test.sv
// Self-checking bench: AXI4-Lite register access plus high-speed bus writes.
// Assumes an open-drain SDA with pull-up; write strobes are held all-on.
`timescale 1ns/1ps
module hs_mode_dac_write_slave_test;
  import hsdac_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, sda_out, sda_oe_n, hs_mode, scl, m_sda, sda_line, ack;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [71:0] dac_word;
  int errors, check_count;

  // Open-drain wire, pull-up wins when nobody pulls low
  assign sda_line = m_sda & (sda_oe_n | sda_out);

  hsdac_slave i_hsdac_slave (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .dac_word(dac_word), .hs_mode(hs_mode));

  hsdac_master i_hsdac_master (.aclk(aclk), .sda_line(sda_line), .scl(scl), .sda(m_sda));

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input string nm, input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(nm, er, bresp);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, e, rdata);
    chk(nm, er, rresp);
  endtask

  // One byte on the bus, acknowledge compared with what is expected
  task automatic sendb(input logic [7:0] b, input logic exp);
    i_hsdac_master.tx(b, ack);
    chk("ack", exp, ack);
  endtask

  // Data word as high then low byte; wait out the update after the ack
  task automatic pair(input logic [15:0] w);
    sendb(w[15:8], 1'b1);
    sendb(w[7:0], 1'b1);
    repeat (6) @(posedge aclk);
  endtask

  task automatic addr_ctrl(input logic [7:0] c);
    i_hsdac_master.start();
    sendb(8'h9C, 1'b1);
    sendb(c, 1'b1);
  endtask

  // Watchdog, roughly ten times the expected run
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    results();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    for (int i = 0; i < CHANNELS; i++) begin
      rd("out reset", OFF_OUT_BASE + 12'(4 * i), 32'h00000000, RESP_OKAY);
    end
    rd("config reset", OFF_CONFIG, 32'h00000000, RESP_OKAY);
    rd("unmapped rd", 12'h0FC, 32'h00000000, RESP_SLVERR);
    wr("unmapped wr", 12'h0FC, 32'h00000001, RESP_SLVERR);
    wr("config", OFF_CONFIG, 32'h00000002, RESP_OKAY);
    rd("config", OFF_CONFIG, 32'h00000002, RESP_OKAY);
    $display("test registers finished");
    // Master code with nonzero don't-care bits, never acknowledged
    i_hsdac_master.start();
    sendb(8'h0D, 1'b0);
    repeat (4) @(posedge aclk);
    chk("hs mode on", 1'b1, hs_mode);
    addr_ctrl(8'h12);
    pair(16'hA53C);
    chk("ch1 word", 18'h0A53C, dac_word[35:18]);
    pair(16'h1234);
    chk("ch1 word", 18'h01234, dac_word[35:18]);
    $display("test data pairs finished");
    i_hsdac_master.start();
    sendb(8'h98, 1'b0);
    i_hsdac_master.start();
    sendb(8'h9D, 1'b0);
    addr_ctrl(8'h80);
    sendb(8'h11, 1'b0);
    $display("test refusals finished");
    addr_ctrl(8'h15);
    sendb(8'hC0, 1'b1);
    sendb(8'h00, 1'b1);
    sendb(8'h00, 1'b0);
    rd("temp ch2", OFF_TEMP_BASE + 12'h008, 32'h00030000, RESP_OKAY);
    $display("test power down finished");
    addr_ctrl(8'h06);
    pair(16'hBEEF);
    chk("ch3 held", 18'h00000, dac_word[71:54]);
    rd("temp ch3", OFF_TEMP_BASE + 12'h00C, 32'h0000BEEF, RESP_OKAY);
    addr_ctrl(8'h20);
    pair(16'h0001);
    chk("all words", {18'h0BEEF, 18'h30000, 18'h01234, 18'h00001}, dac_word);
    // Load code 3 acts as a single-channel update
    addr_ctrl(8'h32);
    pair(16'h5555);
    chk("ch1 load 3", 18'h05555, dac_word[35:18]);
    $display("test load modes finished");
    i_hsdac_master.stop();
    repeat (4) @(posedge aclk);
    chk("hs mode off", 1'b0, hs_mode);
    rd("status", OFF_STATUS, 32'h00003200, RESP_OKAY);
    $display("test stop finished");
    results();
  end
endmodule // hs_mode_dac_write_slave_test
